// >>> verilog/dcsp_regs.vh
`ifndef DCSP_REGS_VH
`define DCSP_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DCSP_OFF_SHADOW    12'h000
`define DCSP_OFF_SWITCH    12'h004
`define DCSP_OFF_DIVIDER   12'h008
`define DCSP_OFF_CORE      12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCSP_SEL_HI        3
`define DCSP_SEL_LO        0
`define DCSP_SUT_HI        5
`define DCSP_SUT_LO        4
`define DCSP_CLK_OUT_BIT   6
`define DCSP_CCE_BIT       7
`define DCSP_RDY_BIT       4
`define DCSP_PCE_BIT       7
`define DCSP_RCF_BIT       2

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define DCSP_CMD_DISABLE   4'h1
`define DCSP_CMD_ENABLE    4'h2
`define DCSP_CMD_REQUEST   4'h3
`define DCSP_CMD_SWITCH    4'h4
`define DCSP_CMD_RECOVER   4'h5
`define DCSP_UNLOCK_BYTE   8'h80

// ----------------------------------------------------------------
// Source codes and source indices
// ----------------------------------------------------------------
`define DCSP_CODE_EXT      4'h0
`define DCSP_CODE_PLL_RC   4'h1
`define DCSP_CODE_RC8      4'h2
`define DCSP_CODE_WDT      4'h3
`define DCSP_CODE_PLL_XT   4'h4
`define DCSP_CODE_PLL_EXT  4'h5
`define DCSP_CODE_RC1      4'h6
`define DCSP_CODE_XTAL_BIT 3
`define DCSP_IDX_RC        0
`define DCSP_IDX_WDT       1
`define DCSP_IDX_EXT       2
`define DCSP_IDX_XTAL      3
`define DCSP_IDX_PLL       4
`define DCSP_NSRC          5

// ----------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------
`define DCSP_ARM_CYCLES    3'd4
`define DCSP_RDY_CNT0      15'd64
`define DCSP_RDY_CNT1      15'd256
`define DCSP_RDY_CNT2      15'd1024
`define DCSP_DIV_RESET     4'h0
`define DCSP_DIV_MAX       4'h8

`endif

// >>> verilog/dcsp_prescaler.v
`timescale 1ns/1ps
`default_nettype none

`include "dcsp_regs.vh"

module dcsp_prescaler (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       load_i,
    input  wire [3:0] sel_i,
    output reg        tick_o
);

    reg  [7:0] cnt_q;
    reg  [3:0] sel_q;
    reg  [3:0] pend_sel_q;
    reg        pend_q;
    wire [7:0] mask;
    wire       hit;

    assign mask = (8'h01 << sel_q) - 8'h01;
    assign hit  = (cnt_q & mask) == mask;

    // New ratio waits for the old period to end, then counts afresh,
    // so no shortened period is ever produced.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q      <= 8'h00;
            sel_q      <= `DCSP_DIV_RESET;
            pend_sel_q <= `DCSP_DIV_RESET;
            pend_q     <= 1'b0;
            tick_o     <= 1'b0;
        end else begin
            tick_o <= hit;
            if (load_i) begin
                pend_sel_q <= sel_i;
                pend_q     <= 1'b1;
            end
            if (hit && pend_q && !load_i) begin
                sel_q  <= pend_sel_q;
                pend_q <= 1'b0;
                cnt_q  <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

endmodule

`default_nettype wire

// >>> verilog/dcsp_top.v
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "dcsp_regs.vh"

module dcsp_top #(
    parameter [14:0] RDY_CNT3 = 15'd16384
) (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire [7:0]  fuse_low_i,
    input  wire [4:0]  src_osc_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg  [4:0]  src_en_o,
    output reg  [9:0]  src_sut_o,
    output reg  [4:0]  sys_src_o,
    output reg         clk_out_en_o,
    output reg         rc_freq_sel_o,
    output wire        clk_cpu_en_o,
    output wire        clk_io_en_o,
    output wire        clk_adc_en_o,
    output wire        clk_flash_en_o
);

    // ------------------------------------------------------------
    // Source code decode
    // ------------------------------------------------------------
    function [2:0] src_idx;
        input [3:0] code;
        begin
            if (code[`DCSP_CODE_XTAL_BIT])
                src_idx = `DCSP_IDX_XTAL;
            else if (code == `DCSP_CODE_EXT)
                src_idx = `DCSP_IDX_EXT;
            else if (code == `DCSP_CODE_WDT)
                src_idx = `DCSP_IDX_WDT;
            else if (code == `DCSP_CODE_RC8 || code == `DCSP_CODE_RC1)
                src_idx = `DCSP_IDX_RC;
            else if (code == `DCSP_CODE_PLL_RC ||
                     code == `DCSP_CODE_PLL_XT ||
                     code == `DCSP_CODE_PLL_EXT)
                src_idx = `DCSP_IDX_PLL;
            else
                src_idx = 3'd7;
        end
    endfunction

    function [2:0] pll_ref;
        input [3:0] code;
        begin
            if (code == `DCSP_CODE_PLL_XT)
                pll_ref = `DCSP_IDX_XTAL;
            else if (code == `DCSP_CODE_PLL_EXT)
                pll_ref = `DCSP_IDX_EXT;
            else
                pll_ref = `DCSP_IDX_RC;
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_COUNT = 2'b10;

    reg         init_done_q;
    reg  [6:0]  shadow_q;
    reg  [3:0]  last_cmd_q;
    reg         cce_q;
    reg  [2:0]  cce_cnt_q;
    reg         ready_q;
    reg  [3:0]  sys_code_q;
    reg  [3:0]  pll_code_q;
    reg  [3:0]  div_sel_q;
    reg         pce_q;
    reg  [2:0]  pce_cnt_q;
    reg  [1:0]  state_q;
    reg  [2:0]  cnt_src_q;
    reg  [14:0] cnt_q;
    reg  [14:0] cnt_end_q;
    reg  [4:0]  osc_s1_q;
    reg  [4:0]  osc_s2_q;
    reg  [4:0]  osc_s3_q;

    wire        acc;
    wire        wr;
    wire        mapped;
    wire [7:0]  wbyte;
    wire [3:0]  cmd_sel;
    wire [1:0]  cmd_sut;
    wire [2:0]  tgt;
    wire [2:0]  sys_idx;
    wire        cmd_go;
    wire        div_load;
    wire        osc_rise;
    reg  [14:0] sut_cnt;
    reg  [31:0] rdata;

    assign acc     = psel_i & penable_i & ~pready_o;
    assign wr      = psel_i & penable_i & pready_o & pwrite_i;
    assign wbyte   = pwdata_i[7:0];
    assign cmd_sel = shadow_q[`DCSP_SEL_HI:`DCSP_SEL_LO];
    assign cmd_sut = shadow_q[`DCSP_SUT_HI:`DCSP_SUT_LO];
    assign tgt     = src_idx(cmd_sel);
    assign sys_idx = src_idx(sys_code_q);
    assign mapped  = paddr_i == `DCSP_OFF_SHADOW  ||
                     paddr_i == `DCSP_OFF_SWITCH  ||
                     paddr_i == `DCSP_OFF_DIVIDER ||
                     paddr_i == `DCSP_OFF_CORE;

    // Command write counts only while armed and with the unlock bit low
    assign cmd_go   = wr && paddr_i == `DCSP_OFF_SWITCH && cce_q &&
                      !wbyte[`DCSP_CCE_BIT];
    assign div_load = wr && paddr_i == `DCSP_OFF_DIVIDER && pce_q &&
                      !wbyte[`DCSP_PCE_BIT] &&
                      wbyte[3:0] <= `DCSP_DIV_MAX;

    always @* begin
        case (cmd_sut)
            2'd0:    sut_cnt = `DCSP_RDY_CNT0;
            2'd1:    sut_cnt = `DCSP_RDY_CNT1;
            2'd2:    sut_cnt = `DCSP_RDY_CNT2;
            default: sut_cnt = RDY_CNT3;
        endcase
    end

    // ------------------------------------------------------------
    // Oscillator sampling
    // ------------------------------------------------------------
    // Counting uses sampled edges, so sources must be well below half
    // of the master clock for an exact count.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            osc_s1_q <= 5'h00;
            osc_s2_q <= 5'h00;
            osc_s3_q <= 5'h00;
        end else begin
            osc_s1_q <= src_osc_i;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign osc_rise = osc_s2_q[cnt_src_q] & ~osc_s3_q[cnt_src_q];

    // ------------------------------------------------------------
    // Clock switch control
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            init_done_q   <= 1'b0;
            shadow_q      <= 7'h00;
            last_cmd_q    <= 4'h0;
            cce_q         <= 1'b0;
            cce_cnt_q     <= 3'd0;
            ready_q       <= 1'b0;
            sys_code_q    <= 4'h0;
            pll_code_q    <= 4'h0;
            src_en_o      <= 5'h00;
            src_sut_o     <= 10'h000;
            sys_src_o     <= 5'h00;
            clk_out_en_o  <= 1'b0;
            rc_freq_sel_o <= 1'b0;
            state_q       <= ST_IDLE;
            cnt_src_q     <= 3'd0;
            cnt_q         <= 15'd0;
            cnt_end_q     <= 15'd0;
        end else if (!init_done_q) begin
            init_done_q <= 1'b1;
            shadow_q    <= fuse_low_i[6:0];
            sys_code_q  <= fuse_low_i[3:0];
            pll_code_q  <= fuse_low_i[3:0];
            src_en_o    <= 5'h01 << src_idx(fuse_low_i[3:0]);
            sys_src_o   <= 5'h01 << src_idx(fuse_low_i[3:0]);
            rc_freq_sel_o <= fuse_low_i[3:0] == `DCSP_CODE_RC1;
        end else begin
            clk_out_en_o <= shadow_q[`DCSP_CLK_OUT_BIT];
            if (cce_q) begin
                if (cce_cnt_q == `DCSP_ARM_CYCLES - 3'd1 || cmd_go)
                    cce_q <= 1'b0;
                cce_cnt_q <= cce_cnt_q + 3'd1;
            end else if (wr && paddr_i == `DCSP_OFF_SWITCH &&
                         wbyte == `DCSP_UNLOCK_BYTE) begin
                cce_q     <= 1'b1;
                cce_cnt_q <= 3'd0;
            end
            if (wr && paddr_i == `DCSP_OFF_SHADOW)
                shadow_q <= wbyte[6:0];
            if (wr && paddr_i == `DCSP_OFF_CORE && src_en_o[`DCSP_IDX_RC])
                rc_freq_sel_o <= wbyte[`DCSP_RCF_BIT];
            if (!src_en_o[`DCSP_IDX_RC])
                rc_freq_sel_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                end
                ST_COUNT: begin
                    if (osc_rise)
                        cnt_q <= cnt_q + 15'd1;
                    if (osc_rise && cnt_q + 15'd1 >= cnt_end_q) begin
                        ready_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (cmd_go && tgt != 3'd7) begin
                last_cmd_q <= wbyte[3:0];
                case (wbyte[3:0])
                    `DCSP_CMD_ENABLE: begin
                        if (!((tgt == `DCSP_IDX_EXT &&
                               src_en_o[`DCSP_IDX_XTAL]) ||
                              (tgt == `DCSP_IDX_XTAL &&
                               src_en_o[`DCSP_IDX_EXT]) ||
                              (tgt == `DCSP_IDX_PLL &&
                               sys_idx == `DCSP_IDX_PLL))) begin
                            src_en_o[tgt] <= 1'b1;
                            src_sut_o[2*tgt +: 2] <= cmd_sut;
                            if (tgt == `DCSP_IDX_PLL) begin
                                pll_code_q <= cmd_sel;
                                src_en_o[pll_ref(cmd_sel)] <= 1'b1;
                            end
                        end
                    end
                    `DCSP_CMD_DISABLE: begin
                        if (tgt != sys_idx &&
                            !(sys_idx == `DCSP_IDX_PLL &&
                              tgt == pll_ref(pll_code_q))) begin
                            src_en_o[tgt]         <= 1'b0;
                            src_sut_o[2*tgt +: 2] <= cmd_sut;
                        end
                    end
                    `DCSP_CMD_REQUEST: begin
                        src_sut_o[2*tgt +: 2] <= cmd_sut;
                        ready_q   <= 1'b0;
                        cnt_src_q <= tgt;
                        cnt_q     <= 15'd0;
                        cnt_end_q <= sut_cnt;
                        state_q   <= ST_COUNT;
                    end
                    `DCSP_CMD_SWITCH: begin
                        if (src_en_o[tgt] &&
                            !(tgt == `DCSP_IDX_PLL &&
                              cmd_sel != pll_code_q) &&
                            !(sys_idx == `DCSP_IDX_EXT &&
                              tgt == `DCSP_IDX_XTAL) &&
                            !(sys_idx == `DCSP_IDX_XTAL &&
                              tgt == `DCSP_IDX_EXT) &&
                            !(tgt == sys_idx &&
                              tgt == `DCSP_IDX_RC)) begin
                            src_sut_o[2*tgt +: 2] <= cmd_sut;
                            sys_code_q <= cmd_sel;
                            sys_src_o  <= 5'h01 << tgt;
                        end
                    end
                    `DCSP_CMD_RECOVER: begin
                        shadow_q[`DCSP_SEL_HI:`DCSP_SEL_LO] <=
                            sys_code_q;
                    end
                    default: last_cmd_q <= last_cmd_q;
                endcase
            end else if (cmd_go && wbyte[3:0] == `DCSP_CMD_RECOVER) begin
                last_cmd_q <= wbyte[3:0];
                shadow_q[`DCSP_SEL_HI:`DCSP_SEL_LO] <= sys_code_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Divider register
    // ------------------------------------------------------------
    // Rewriting the unlock during the window neither extends nor
    // clears it.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_sel_q <= `DCSP_DIV_RESET;
            pce_q     <= 1'b0;
            pce_cnt_q <= 3'd0;
        end else begin
            if (pce_q) begin
                if (pce_cnt_q == `DCSP_ARM_CYCLES - 3'd1 || div_load)
                    pce_q <= 1'b0;
                pce_cnt_q <= pce_cnt_q + 3'd1;
            end else if (wr && paddr_i == `DCSP_OFF_DIVIDER &&
                         wbyte == `DCSP_UNLOCK_BYTE) begin
                pce_q     <= 1'b1;
                pce_cnt_q <= 3'd0;
            end
            if (div_load)
                div_sel_q <= wbyte[3:0];
        end
    end

    dcsp_prescaler u_presc (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (div_load),
        .sel_i   (wbyte[3:0]),
        .tick_o  (clk_cpu_en_o)
    );

    assign clk_io_en_o    = clk_cpu_en_o;
    assign clk_adc_en_o   = clk_cpu_en_o;
    assign clk_flash_en_o = clk_cpu_en_o;

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    always @* begin
        rdata = 32'h0000_0000;
        case (paddr_i)
            `DCSP_OFF_SHADOW:  rdata[6:0] = shadow_q;
            `DCSP_OFF_SWITCH: begin
                rdata[`DCSP_CCE_BIT] = cce_q;
                rdata[`DCSP_RDY_BIT] = ready_q;
                rdata[3:0]           = last_cmd_q;
            end
            `DCSP_OFF_DIVIDER: begin
                rdata[`DCSP_PCE_BIT] = pce_q;
                rdata[3:0]           = div_sel_q;
            end
            `DCSP_OFF_CORE:    rdata[`DCSP_RCF_BIT] = rc_freq_sel_o;
            default:           rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= acc;
            pslverr_o <= acc & ~mapped;
            if (acc && !pwrite_i)
                prdata_o <= rdata;
        end
    end

endmodule

`default_nettype wire

// >>> dv/dcsp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module dcsp_top_sva #(
    parameter [14:0] RDY_CNT3 = 15'd16384
) (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire [4:0]  src_en_o,
    input wire [4:0]  sys_src_o,
    input wire        clk_out_en_o,
    input wire        rc_freq_sel_o,
    input wire        clk_cpu_en_o,
    input wire        clk_io_en_o,
    input wire        clk_adc_en_o,
    input wire        clk_flash_en_o
);
    // Fuse capture lands over the first edges, so wait it out
    logic [1:0] up_q;
    wire        live  = &up_q;
    wire        sw_wr = pready_o && pwrite_i && paddr_i == 12'h004;
    wire        sh_wr = pready_o && pwrite_i && paddr_i == 12'h000;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            up_q <= 2'h0;
        end else if (!live) begin
            up_q <= up_q + 2'h1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_one_wait: assert property (
        psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access did not end after one wait");
    chk_err_resp: assert property (
        pready_o |-> pslverr_o == !(paddr_i == 12'h000 ||
        paddr_i == 12'h004 || paddr_i == 12'h008 || paddr_i == 12'h00C))
        else $error("error response does not match address");
    chk_rd_upper: assert property (
        pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_div_joint: assert property (
        clk_cpu_en_o == clk_io_en_o && clk_adc_en_o == clk_flash_en_o
        && clk_cpu_en_o == clk_adc_en_o)
        else $error("divided clock enables differ");
    chk_sys_onehot: assert property ($onehot0(sys_src_o))
        else $error("system source not one-hot");
    chk_sys_enabled: assert property (
        (sys_src_o & ~src_en_o) == 5'h0)
        else $error("system source is not enabled");
    chk_ext_xtal: assert property (!(src_en_o[2] && src_en_o[3]))
        else $error("both external sources enabled");
    chk_pll_ref: assert property (
        sys_src_o[4] |-> |(src_en_o & 5'h0d))
        else $error("PLL runs system with no reference");
    chk_en_by_cmd: assert property (
        live && $changed(src_en_o) |-> $past(sw_wr) || $past(sw_wr, 2))
        else $error("source enables moved without command");
    chk_clk_out: assert property (
        sh_wr |-> ##2 clk_out_en_o == $past(pwdata_i[6], 2))
        else $error("clock output does not follow shadow");
    chk_rcf_clear: assert property (
        $fell(src_en_o[0]) |-> ##[0:2] !rc_freq_sel_o)
        else $error("RC frequency select kept with RC off");
endmodule

bind dcsp_top dcsp_top_sva #(.RDY_CNT3(RDY_CNT3)) dcsp_top_sva_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .src_en_o(src_en_o), .sys_src_o(sys_src_o),
    .clk_out_en_o(clk_out_en_o), .rc_freq_sel_o(rc_freq_sel_o),
    .clk_cpu_en_o(clk_cpu_en_o), .clk_io_en_o(clk_io_en_o),
    .clk_adc_en_o(clk_adc_en_o), .clk_flash_en_o(clk_flash_en_o)
);

`default_nettype wire

// >>> dv/dcsp_top_test.sv
`timescale 1ns/1ps
`default_nettype none

`include "dcsp_regs.vh"

module dcsp_top_test;
    logic        clk_i;
    logic        rst_n_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [7:0]  fuse_low_i;
    logic [4:0]  src_osc_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] rdat;
    logic        serr;
    wire  [31:0] prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire  [4:0]  src_en_o;
    wire  [9:0]  src_sut_o;
    wire  [4:0]  sys_src_o;
    wire         clk_out_en_o;
    wire         rc_freq_sel_o;
    wire  [3:0]  tick;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;

    dcsp_top #(.RDY_CNT3(15'd16)) dcsp_top_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .fuse_low_i(fuse_low_i),
        .src_osc_i(src_osc_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .src_en_o(src_en_o), .src_sut_o(src_sut_o),
        .sys_src_o(sys_src_o), .clk_out_en_o(clk_out_en_o),
        .rc_freq_sel_o(rc_freq_sel_o), .clk_cpu_en_o(tick[0]),
        .clk_io_en_o(tick[1]), .clk_adc_en_o(tick[2]),
        .clk_flash_en_o(tick[3])
    );

    // ------------------------------------------------------------
    // Clock, timeout, reporting
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------
    // Bus and stimulus helpers
    // ------------------------------------------------------------
    // Keeps psel up when another transfer follows at once
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              input bit last);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rdat = prdata_o;
        serr = pslverr_o;
        if (last) begin
            psel_i    <= 1'b0;
            penable_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b1);
    endtask

    task rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0, 1'b1);
    endtask

    // Unlock and command go back to back to fit the arm window
    task sc(input logic [7:0] v, input logic [3:0] c);
        wr(`DCSP_OFF_SHADOW, {24'h0, v});
        xfer(1'b1, `DCSP_OFF_SWITCH, {24'h0, `DCSP_UNLOCK_BYTE}, 1'b0);
        xfer(1'b1, `DCSP_OFF_SWITCH, {28'h0, c}, 1'b1);
        repeat (2) @(posedge clk_i);
    endtask

    task div(input logic [3:0] v);
        xfer(1'b1, `DCSP_OFF_DIVIDER, {24'h0, `DCSP_UNLOCK_BYTE}, 1'b0);
        xfer(1'b1, `DCSP_OFF_DIVIDER, {28'h0, v}, 1'b1);
    endtask

    // Skips the changeover, then measures one settled tick spacing
    task gap(input int exp);
        int n;
        for (int k = 0; k < 4; k++) begin
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (tick[0] !== 1'b1 && n < 600);
        end
        check(n, exp);
    endtask

    task osc(input int k);
        repeat (k) begin
            src_osc_i[1] <= 1'b1;
            repeat (4) @(posedge clk_i);
            src_osc_i[1] <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask

    task poll(input logic [3:0] code);
        rdat = 32'h0;
        for (int i = 0; i < 8 && rdat[3:0] !== code; i++) begin
            sc(8'h00, `DCSP_CMD_RECOVER);
            rd(`DCSP_OFF_SHADOW);
        end
        check(rdat, {28'h0, code});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_fuse;
        rd(`DCSP_OFF_SHADOW);
        check(rdat, 32'h52);
        check(src_en_o, 5'h01);
        check(sys_src_o, 5'h01);
        check(clk_out_en_o, 1'b1);
    endtask

    task t_lock;
        wr(`DCSP_OFF_SHADOW, 32'h03);
        wr(`DCSP_OFF_SWITCH, {28'h0, `DCSP_CMD_ENABLE});
        check(src_en_o, 5'h01);
        for (int i = 0; i < 3; i++) begin
            sc(8'h03, 4'(7 + 4 * i));
            check(src_en_o, 5'h01);
        end
    endtask

    task t_req;
        sc(8'h13, `DCSP_CMD_ENABLE);
        check(src_en_o, 5'h03);
        check(src_sut_o[3:2], 2'h1);
        sc(8'h03, `DCSP_CMD_REQUEST);
        check(src_sut_o[3:2], 2'h0);
        rd(`DCSP_OFF_SWITCH);
        check(rdat[4], 1'b0);
        osc(63);
        rd(`DCSP_OFF_SWITCH);
        check(rdat[4], 1'b0);
        osc(1);
        repeat (8) @(posedge clk_i);
        rd(`DCSP_OFF_SWITCH);
        check(rdat[4], 1'b1);
    endtask

    task t_switch;
        wr(`DCSP_OFF_CORE, 32'h4);
        check(rc_freq_sel_o, 1'b1);
        sc(8'h03, `DCSP_CMD_SWITCH);
        poll(`DCSP_CODE_WDT);
        check(sys_src_o, 5'h02);
        sc(8'h03, `DCSP_CMD_DISABLE);
        check(src_en_o, 5'h03);
        sc(8'h02, `DCSP_CMD_DISABLE);
        check(src_en_o, 5'h02);
        check(rc_freq_sel_o, 1'b0);
    endtask

    task t_ext;
        sc(8'h00, `DCSP_CMD_ENABLE);
        check(src_en_o, 5'h06);
        sc(8'h08, `DCSP_CMD_ENABLE);
        check(src_en_o, 5'h06);
        sc(8'h00, `DCSP_CMD_DISABLE);
        check(src_en_o, 5'h02);
        sc(8'h01, `DCSP_CMD_ENABLE);
        check(src_en_o, 5'h13);
        sc(8'h01, `DCSP_CMD_SWITCH);
        poll(`DCSP_CODE_PLL_RC);
        check(sys_src_o, 5'h10);
        sc(8'h02, `DCSP_CMD_DISABLE);
        check(src_en_o[0], 1'b1);
    endtask

    task t_div;
        gap(1);
        div(4'h3);
        rd(`DCSP_OFF_DIVIDER);
        check(rdat, 32'h3);
        gap(8);
        wr(`DCSP_OFF_DIVIDER, 32'h1);
        rd(`DCSP_OFF_DIVIDER);
        check(rdat, 32'h3);
        wr(`DCSP_OFF_DIVIDER, {24'h0, `DCSP_UNLOCK_BYTE});
        repeat (4) @(posedge clk_i);
        wr(`DCSP_OFF_DIVIDER, 32'h1);
        rd(`DCSP_OFF_DIVIDER);
        check(rdat, 32'h3);
        div(4'h9);
        rd(`DCSP_OFF_DIVIDER);
        check(rdat[3:0], 4'h3);
        repeat (6) @(posedge clk_i);
        div(`DCSP_DIV_MAX);
        gap(256);
        div(4'h0);
        gap(1);
    endtask

    task t_unmapped;
        rd(12'h010);
        check(serr, 1'b1);
        check(rdat, 32'h0);
    endtask

    initial begin
        rst_n_i    = 1'b0;
        psel_i     = 1'b0;
        penable_i  = 1'b0;
        pwrite_i   = 1'b0;
        paddr_i    = 12'h000;
        pwdata_i   = 32'h0;
        fuse_low_i = 8'h52;
        src_osc_i  = 5'h00;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_fuse;
        t_lock;
        t_req;
        t_switch;
        t_ext;
        t_div;
        t_unmapped;
        close_out;
    end
endmodule

`default_nettype wire
